//--- bafe_defines.vh
// register map, field positions and reset values of the battery front end
`ifndef BAFE_DEFINES_VH
`define BAFE_DEFINES_VH

// register offsets
`define BAFE_ADDR_IDENTITY_WAKE    8'h00
`define BAFE_ADDR_FAULT_STATUS     8'h01
`define BAFE_ADDR_CELL_BALANCE     8'h02
`define BAFE_ADDR_ANALOG_SELECT    8'h03
`define BAFE_ADDR_FET_DRIVE        8'h04
`define BAFE_ADDR_DISCHARGE_SETUP  8'h05
`define BAFE_ADDR_CHARGE_SETUP     8'h06
`define BAFE_ADDR_FEATURE_SETUP    8'h07
`define BAFE_ADDR_WRITE_UNLOCK     8'h08

// identity and wake status fields
`define BAFE_BIT_SINGLE_UNIT       5
`define BAFE_BIT_WAKE_STATE        4

// fet drive control fields
`define BAFE_BIT_SLEEP             7
`define BAFE_BIT_LOAD_MON          6
`define BAFE_BIT_CHARGE_DRIVE      1
`define BAFE_BIT_DISCHARGE_DRIVE   0

// discharge setup fields
`define BAFE_BIT_DIS_OC_AUTO_OFF   7
`define BAFE_BIT_SHORT_AUTO_OFF    4

// charge setup fields
`define BAFE_BIT_CHG_OC_AUTO_OFF   7
`define BAFE_BIT_CHG_DELAY_DIV     3
`define BAFE_BIT_DIS_DELAY_DIV     2

// feature setup fields
`define BAFE_BIT_TEMP_SCAN_OFF     7
`define BAFE_BIT_EXT_THERM_OFF     4
`define BAFE_BIT_INT_THERM_OFF     3
`define BAFE_BIT_WAKE_DISABLE      1
`define BAFE_BIT_WAKE_POLARITY     0

// write unlock fields
`define BAFE_BIT_FEATURE_UNLOCK    7
`define BAFE_BIT_CHARGE_UNLOCK     6
`define BAFE_BIT_DISCHARGE_UNLOCK  5

// writable bit masks of the plain registers, reserved bits excluded
`define BAFE_MASK_CELL_BALANCE     8'hFE
`define BAFE_MASK_ANALOG_SELECT    8'hCF
`define BAFE_MASK_FET_DRIVE        8'hC3
`define BAFE_MASK_WRITE_UNLOCK     8'hF8

// reset value of every register except the identity register, whose single unit bit reads one
`define BAFE_RESET_VALUE           8'h00

// serial device address, arbitrary value
`define BAFE_DEVICE_ADDRESS        7'h28

`endif

//--- bafe_sync.v
// two flip-flop synchroniser for a group of asynchronous inputs
`timescale 1ns/1ps
module bafe_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             rst_n_in,
  // asynchronous input and synchronised output
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg; // first stage, read only by the second

  ////////////////////////////////////////////////////////////////////////////
  // two stages clocked back to back
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

//--- bafe_fault_flag.v
// one latched fault flag that clears on read once its condition is gone
`timescale 1ns/1ps
module bafe_fault_flag (
  // clock and reset
  input  wire clk_in,
  input  wire rst_n_in,
  // condition and read strobe
  input  wire cond_in,
  input  wire read_clear_in,
  // latched flag
  output reg  flag_out
);

  ////////////////////////////////////////////////////////////////////////////
  // a live condition always wins over the read clear
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else if (cond_in) begin
      flag_out <= 1'b1; // RULE1
    end else if (read_clear_in) begin
      flag_out <= 1'b0; // RULE5
    end
  end

endmodule

//--- bafe_register_bank.v
// register bank of the battery front end with its two-wire serial slave
// Notes on behaviour
// RULE1: written ones act; read status ones are real
// RULE2: host writes reserved bits as zero
// RULE3: host never writes addresses nine and above
// RULE4: host ignores reserved bits on reads
// RULE5: fault flags clear on read once gone
// RULE6: wake status follows the pin directly; here it shows the pin at its active level, inverted at reset polarity
// RULE7: sleep clears at power-up, wake, write zero
// RULE8: protection events clear both fet drive bits
// RULE9: fet writes drive outputs, reads show drive
// RULE10: bit one charge fet, bit zero discharge
// RULE11: feature setup writes need unlock bit seven
// RULE12: charge setup writes need unlock bit six
// RULE13: discharge setup writes need unlock bit five
// RULE14: charge setup bit three divides charge delay
// RULE15: charge setup bit two divides discharge delay
// RULE16: discharge auto-off bits zero enable shutdown
// RULE17: charge auto-off bit zero enables shutdown
// RULE18: feature setup holds disables and wake polarity
// RULE19: locked writes change nothing at all
`timescale 1ns/1ps
`include "bafe_defines.vh"
module bafe_register_bank (
  // clock and reset
  input  wire       mclk_in,
  input  wire       rst_n_in,
  // serial link, open drain
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  // wake pin and analog fault conditions
  input  wire       wake_pin_in,
  input  wire       ext_overtemp_in,
  input  wire       int_overtemp_in,
  input  wire       load_failure_in,
  input  wire       discharge_short_in,
  input  wire       discharge_overcurrent_in,
  input  wire       charge_overcurrent_in,
  // control outputs
  output reg  [7:1] balance_switch_out,
  output reg  [3:0] analog_select_out,
  output reg        charge_switch_drive_out,
  output reg        discharge_switch_drive_out,
  output reg        load_monitor_connect_out,
  output reg        sleep_out,
  // protection and feature configuration outputs
  output reg        discharge_oc_auto_on_out,
  output reg        short_auto_on_out,
  output reg        charge_oc_auto_on_out,
  output reg        charge_delay_divider_out,
  output reg        discharge_delay_divider_out,
  output reg  [7:0] discharge_setup_out,
  output reg  [7:0] charge_setup_out,
  output reg  [7:0] feature_setup_out
);

  // serial engine states
  localparam [3:0] ST_IDLE    = 4'h0;
  localparam [3:0] ST_ADDR    = 4'h1;
  localparam [3:0] ST_ADDR_AK = 4'h2;
  localparam [3:0] ST_PTR     = 4'h3;
  localparam [3:0] ST_PTR_AK  = 4'h4;
  localparam [3:0] ST_WR      = 4'h5;
  localparam [3:0] ST_WR_AK   = 4'h6;
  localparam [3:0] ST_RD      = 4'h7;
  localparam [3:0] ST_RD_AK   = 4'h8;

  wire [8:0] sync_w;           // synchronised pins
  wire       scl_s;            // synchronised clock line
  wire       sda_s;            // synchronised data line
  wire       wake_s;           // synchronised wake pin
  wire [5:0] cond_s;           // synchronised fault conditions
  wire [5:0] fault_w;          // latched fault flags
  reg        scl_prev_reg;     // last clock line level
  reg        sda_prev_reg;     // last data line level
  reg  [3:0] state_reg;        // serial engine state
  reg  [3:0] cnt_reg;          // bit counter
  reg  [7:0] shift_reg;        // shift register of the current byte
  reg  [7:0] ptr_reg;          // register pointer
  reg        rw_reg;           // high for a read transfer
  reg        wr_stb_reg;       // one-cycle write strobe
  reg  [7:0] wr_data_reg;      // data of the write strobe
  reg  [7:0] wr_addr_reg;      // address of the write strobe
  reg        rd_clr_reg;       // fault status read strobe
  reg  [7:0] analog_reg;       // analog select and user flags
  reg  [7:0] unlock_reg;       // write unlock and user flags
  reg        wake_state_reg;   // wake pin at its active level
  reg        oc_prev_reg;      // last protection trip level
  reg  [7:0] rd_mux;           // read data of the pointed register
  wire       scl_rise;         // clock line rising
  wire       scl_fall;         // clock line falling
  wire       start_evt;        // start or repeated start
  wire       stop_evt;         // stop
  wire       wake_act;         // wake pin at active level
  wire       oc_trip;          // protection switched the fets off
  wire       wr_fet;           // write strobe to fet_drive_control

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers and fault flags

  bafe_sync #(.WIDTH(9)) u_sync (
    .clk_in   (mclk_in),
    .rst_n_in (rst_n_in),
    .async_in ({scl_in, sda_in, wake_pin_in, ext_overtemp_in,
                int_overtemp_in, load_failure_in, discharge_short_in,
                discharge_overcurrent_in, charge_overcurrent_in}),
    .sync_out (sync_w)
  );

  assign scl_s  = sync_w[8];
  assign sda_s  = sync_w[7];
  assign wake_s = sync_w[6];
  assign cond_s = sync_w[5:0];

  // flags in fault status bit order: ext, int, load, short, dis oc, chg oc
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      bafe_fault_flag u_flag (
        .clk_in        (mclk_in),
        .rst_n_in      (rst_n_in),
        .cond_in       (cond_s[gi]),
        .read_clear_in (rd_clr_reg),
        .flag_out      (fault_w[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // line events
  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign scl_fall  = ~scl_s & scl_prev_reg;
  assign start_evt = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_evt  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  ////////////////////////////////////////////////////////////////////////////
  // read data multiplexer, reserved bits and unmapped addresses read zero
  always @* begin
    rd_mux = `BAFE_RESET_VALUE;
    case (ptr_reg)
      `BAFE_ADDR_IDENTITY_WAKE: begin
        rd_mux[`BAFE_BIT_SINGLE_UNIT] = 1'b1;
        rd_mux[`BAFE_BIT_WAKE_STATE]  = wake_state_reg; // RULE6
      end
      `BAFE_ADDR_FAULT_STATUS: begin
        rd_mux[5:0] = fault_w; // RULE1
      end
      `BAFE_ADDR_CELL_BALANCE: begin
        rd_mux[7:1] = balance_switch_out;
      end
      `BAFE_ADDR_ANALOG_SELECT: begin
        rd_mux = analog_reg;
      end
      `BAFE_ADDR_FET_DRIVE: begin
        rd_mux[`BAFE_BIT_SLEEP]           = sleep_out;
        rd_mux[`BAFE_BIT_LOAD_MON]        = load_monitor_connect_out;
        rd_mux[`BAFE_BIT_CHARGE_DRIVE]    = charge_switch_drive_out; // RULE9
        rd_mux[`BAFE_BIT_DISCHARGE_DRIVE] = discharge_switch_drive_out;
      end
      `BAFE_ADDR_DISCHARGE_SETUP: begin
        rd_mux = discharge_setup_out;
      end
      `BAFE_ADDR_CHARGE_SETUP: begin
        rd_mux = charge_setup_out;
      end
      `BAFE_ADDR_FEATURE_SETUP: begin
        rd_mux = feature_setup_out;
      end
      `BAFE_ADDR_WRITE_UNLOCK: begin
        rd_mux = unlock_reg;
      end
      default: begin
        rd_mux = `BAFE_RESET_VALUE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial slave engine: address, pointer, write and read bytes
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      state_reg    <= ST_IDLE;
      cnt_reg      <= 4'h0;
      shift_reg    <= 8'h00;
      ptr_reg      <= 8'h00;
      rw_reg       <= 1'b0;
      wr_stb_reg   <= 1'b0;
      wr_data_reg  <= 8'h00;
      wr_addr_reg  <= 8'h00;
      rd_clr_reg   <= 1'b0;
      sda_out      <= 1'b0;
      sda_oe_out   <= 1'b0;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
      wr_stb_reg   <= 1'b0;
      rd_clr_reg   <= 1'b0;
      sda_out      <= 1'b0;
      if (start_evt) begin
        // a start restarts address reception from any state
        state_reg  <= ST_ADDR;
        cnt_reg    <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop_evt) begin
        state_reg  <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_PTR, ST_WR: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              cnt_reg   <= cnt_reg + 4'h1;
            end else if (scl_fall && cnt_reg == 4'h8) begin
              cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == `BAFE_DEVICE_ADDRESS) begin
                  rw_reg     <= shift_reg[0];
                  sda_oe_out <= 1'b1;
                  state_reg  <= ST_ADDR_AK;
                end else begin
                  // another device is addressed
                  state_reg <= ST_IDLE;
                end
              end else if (state_reg == ST_PTR) begin
                ptr_reg    <= shift_reg;
                sda_oe_out <= 1'b1;
                state_reg  <= ST_PTR_AK;
              end else begin
                wr_stb_reg  <= 1'b1;
                wr_addr_reg <= ptr_reg;
                wr_data_reg <= shift_reg;
                sda_oe_out  <= 1'b1;
                state_reg   <= ST_WR_AK;
              end
            end
          end
          ST_ADDR_AK, ST_RD_AK: begin
            if (scl_rise && state_reg == ST_RD_AK && sda_s) begin
              // master refused the byte: the read ends
              state_reg <= ST_IDLE;
            end else if (scl_fall) begin
              if (rw_reg) begin
                // load the pointed register and drive its top bit
                shift_reg  <= rd_mux;
                sda_oe_out <= ~rd_mux[7];
                rd_clr_reg <= (ptr_reg == `BAFE_ADDR_FAULT_STATUS); // RULE5
                cnt_reg    <= 4'h0;
                state_reg  <= ST_RD;
              end else begin
                sda_oe_out <= 1'b0;
                state_reg  <= ST_PTR;
              end
            end
          end
          ST_PTR_AK, ST_WR_AK: begin
            if (scl_fall) begin
              sda_oe_out <= 1'b0;
              if (state_reg == ST_WR_AK) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
              state_reg <= ST_WR;
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (cnt_reg == 4'h7) begin
                // release for the master acknowledge
                sda_oe_out <= 1'b0;
                ptr_reg    <= ptr_reg + 8'h01;
                state_reg  <= ST_RD_AK;
              end else begin
                shift_reg  <= {shift_reg[6:0], 1'b0};
                sda_oe_out <= ~shift_reg[6];
                cnt_reg    <= cnt_reg + 4'h1;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wake level and protection trip detection
  assign wake_act = feature_setup_out[`BAFE_BIT_WAKE_POLARITY] ?
                    wake_s : ~wake_s;
  assign oc_trip  =
    (cond_s[1] & ~discharge_setup_out[`BAFE_BIT_DIS_OC_AUTO_OFF]) |
    (cond_s[2] & ~discharge_setup_out[`BAFE_BIT_SHORT_AUTO_OFF]) |
    (cond_s[0] & ~charge_setup_out[`BAFE_BIT_CHG_OC_AUTO_OFF]);
  assign wr_fet   = wr_stb_reg & (wr_addr_reg == `BAFE_ADDR_FET_DRIVE);

  ////////////////////////////////////////////////////////////////////////////
  // control and configuration registers
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      balance_switch_out         <= 7'h00;
      analog_reg                 <= `BAFE_RESET_VALUE;
      analog_select_out          <= 4'h0;
      charge_switch_drive_out    <= 1'b0;
      discharge_switch_drive_out <= 1'b0;
      load_monitor_connect_out   <= 1'b0;
      sleep_out                  <= 1'b0;
      discharge_setup_out        <= `BAFE_RESET_VALUE;
      charge_setup_out           <= `BAFE_RESET_VALUE;
      feature_setup_out          <= `BAFE_RESET_VALUE;
      unlock_reg                 <= `BAFE_RESET_VALUE;
      wake_state_reg             <= 1'b0;
      oc_prev_reg                <= 1'b0;
    end else begin
      wake_state_reg <= wake_act; // RULE6
      oc_prev_reg    <= oc_trip;
      if (wr_stb_reg) begin
        case (wr_addr_reg)
          `BAFE_ADDR_CELL_BALANCE: begin
            balance_switch_out <= wr_data_reg[7:1]; // RULE1
          end
          `BAFE_ADDR_ANALOG_SELECT: begin
            analog_reg        <= wr_data_reg & `BAFE_MASK_ANALOG_SELECT;
            analog_select_out <= wr_data_reg[3:0];
          end
          `BAFE_ADDR_DISCHARGE_SETUP: begin
            if (unlock_reg[`BAFE_BIT_DISCHARGE_UNLOCK]) begin
              discharge_setup_out <= wr_data_reg; // RULE13 RULE19
            end
          end
          `BAFE_ADDR_CHARGE_SETUP: begin
            if (unlock_reg[`BAFE_BIT_CHARGE_UNLOCK]) begin
              charge_setup_out <= wr_data_reg; // RULE12 RULE19
            end
          end
          `BAFE_ADDR_FEATURE_SETUP: begin
            if (unlock_reg[`BAFE_BIT_FEATURE_UNLOCK]) begin
              feature_setup_out <= wr_data_reg; // RULE11 RULE18 RULE19
            end
          end
          `BAFE_ADDR_WRITE_UNLOCK: begin
            unlock_reg <= wr_data_reg & `BAFE_MASK_WRITE_UNLOCK;
          end
          default: begin
            // fet_drive_control handled below, unmapped writes are dropped
            unlock_reg <= unlock_reg;
          end
        endcase
      end
      // fet drive: a fresh protection trip overrides a host write
      if (oc_trip && !oc_prev_reg) begin
        charge_switch_drive_out    <= 1'b0; // RULE8
        discharge_switch_drive_out <= 1'b0; // RULE8
      end else if (wr_fet) begin
        charge_switch_drive_out    <=
          wr_data_reg[`BAFE_BIT_CHARGE_DRIVE]; // RULE9 RULE10
        discharge_switch_drive_out <=
          wr_data_reg[`BAFE_BIT_DISCHARGE_DRIVE]; // RULE9 RULE10
      end
      if (wr_fet) begin
        load_monitor_connect_out <= wr_data_reg[`BAFE_BIT_LOAD_MON];
      end
      // sleep: the wake edge wins over a host write of one
      if (wake_act && !wake_state_reg &&
          !feature_setup_out[`BAFE_BIT_WAKE_DISABLE]) begin
        sleep_out <= 1'b0; // RULE7
      end else if (wr_fet) begin
        sleep_out <= wr_data_reg[`BAFE_BIT_SLEEP]; // RULE7
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decoded enables and dividers for the analog protection timers
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      discharge_oc_auto_on_out    <= 1'b1;
      short_auto_on_out           <= 1'b1;
      charge_oc_auto_on_out       <= 1'b1;
      charge_delay_divider_out    <= 1'b0;
      discharge_delay_divider_out <= 1'b0;
    end else begin
      discharge_oc_auto_on_out    <=
        ~discharge_setup_out[`BAFE_BIT_DIS_OC_AUTO_OFF]; // RULE16
      short_auto_on_out           <=
        ~discharge_setup_out[`BAFE_BIT_SHORT_AUTO_OFF]; // RULE16
      charge_oc_auto_on_out       <=
        ~charge_setup_out[`BAFE_BIT_CHG_OC_AUTO_OFF]; // RULE17
      charge_delay_divider_out    <=
        charge_setup_out[`BAFE_BIT_CHG_DELAY_DIV]; // RULE14
      discharge_delay_divider_out <=
        charge_setup_out[`BAFE_BIT_DIS_DELAY_DIV]; // RULE15
    end
  end

endmodule

//--- bafe_register_bank_checker.sv
// checker of the register bank outputs against their causes
`timescale 1ns/1ps
module bafe_register_bank_checker (
  // clock and reset
  input wire       mclk_in,
  input wire       rst_n_in,
  // pins and fault conditions
  input wire       sda_oe_out,
  input wire       wake_pin_in,
  input wire       discharge_short_in,
  input wire       charge_overcurrent_in,
  // drive and sleep outputs
  input wire       charge_switch_drive_out,
  input wire       discharge_switch_drive_out,
  input wire       sleep_out,
  // configuration outputs
  input wire       discharge_oc_auto_on_out,
  input wire       short_auto_on_out,
  input wire       charge_oc_auto_on_out,
  input wire       charge_delay_divider_out,
  input wire       discharge_delay_divider_out,
  input wire [7:0] discharge_setup_out,
  input wire [7:0] charge_setup_out,
  input wire [7:0] feature_setup_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////
  // setup bits and the enables and dividers they export
  property p_dis_auto;
    1 |-> ##[0:1] (discharge_oc_auto_on_out == !discharge_setup_out[7]);
  endproperty
  a_dis_auto: assert property (p_dis_auto) else $error("dis oc auto");
  property p_short_auto;
    1 |-> ##[0:1] (short_auto_on_out == !discharge_setup_out[4]);
  endproperty
  a_short_auto: assert property (p_short_auto) else $error("short auto");
  property p_chg_auto;
    1 |-> ##[0:1] (charge_oc_auto_on_out == !charge_setup_out[7]);
  endproperty
  a_chg_auto: assert property (p_chg_auto) else $error("chg oc auto");
  property p_chg_div;
    1 |-> ##[0:1] (charge_delay_divider_out == charge_setup_out[3]);
  endproperty
  a_chg_div: assert property (p_chg_div) else $error("chg divider");
  property p_dis_div;
    1 |-> ##[0:1] (discharge_delay_divider_out == charge_setup_out[2]);
  endproperty
  a_dis_div: assert property (p_dis_div) else $error("dis divider");
  ////////////////////////////////////////////////////////////////////////////
  // protection trips drop both drives, wake clears sleep
  property p_trip_chg;
    $rose(charge_overcurrent_in && charge_oc_auto_on_out) |-> ##[1:6]
      (!charge_switch_drive_out && !discharge_switch_drive_out);
  endproperty
  a_trip_chg: assert property (p_trip_chg) else $error("chg trip");
  property p_trip_short;
    $rose(discharge_short_in && short_auto_on_out) |-> ##[1:6]
      (!charge_switch_drive_out && !discharge_switch_drive_out);
  endproperty
  a_trip_short: assert property (p_trip_short) else $error("short trip");
  property p_wake;
    $fell(wake_pin_in) && !feature_setup_out[0] && !feature_setup_out[1]
      |-> ##[1:6] !sleep_out;
  endproperty
  a_wake: assert property (p_wake) else $error("wake sleep");
  // main scenarios reached
  c_trip: cover property ($fell(charge_switch_drive_out));
  c_sleep: cover property ($fell(sleep_out));
  c_ack: cover property ($rose(sda_oe_out));
endmodule
bind bafe_register_bank bafe_register_bank_checker
  u_bafe_register_bank_checker (.*);

//--- bafe_host_model.sv
// host side model: bit-level two-wire master with register access tasks
`timescale 1ns/1ps
`include "bafe_defines.vh"
module bafe_host_model (
  // bus pins, data is open drain
  input  wire sda_in,
  output reg  scl_out,
  output reg  sda_low_out
);
  // idle: both lines released
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // one bit, data set after the slave's release
  task bit_x(input logic b, output logic r);
    #17 sda_low_out = ~b;
    #5 scl_out = 1'b1;
    #5 r = sda_in;
    #5 scl_out = 1'b0;
  endtask
  // start, also serves as repeated start
  task start_c;
    #17 sda_low_out = 1'b0;
    #5 scl_out = 1'b1;
    #16 sda_low_out = 1'b1;
    #16 scl_out = 1'b0;
  endtask
  // stop, leaves the bus idle
  task stop_c;
    #17 sda_low_out = 1'b1;
    #5 scl_out = 1'b1;
    #16 sda_low_out = 1'b0;
    #16;
  endtask
  // eight bits msb first, then acknowledge
  task byte_x(input logic [7:0] tx, input logic ak, output logic [7:0] rx);
    integer i;
    logic   a;
    for (i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(ak, a);
  endtask
  // register write, unmapped addresses never sent
  task wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] x;
    if (a > 8'h08) return;
    start_c;
    byte_x({`BAFE_DEVICE_ADDRESS, 1'b0}, 1'b1, x);
    byte_x(a, 1'b1, x);
    byte_x(d, 1'b1, x);
    stop_c;
  endtask
  // register read through pointer write and repeated start
  task rd(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] x;
    start_c;
    byte_x({`BAFE_DEVICE_ADDRESS, 1'b0}, 1'b1, x);
    byte_x(a, 1'b1, x);
    start_c;
    byte_x({`BAFE_DEVICE_ADDRESS, 1'b1}, 1'b1, x);
    byte_x(8'hFF, 1'b1, d);
    stop_c;
  endtask
endmodule

//--- bafe_register_bank_test.sv
// self-checking bench of the register bank through its serial link
`timescale 1ns/1ps
module bafe_register_bank_test;
  logic       mclk_in = 1'b0;     // system clock
  logic       rst_n_in = 1'b0;    // reset, active low
  logic       wake_pin_in = 1'b1; // wake pin, idle high
  logic [5:0] cond = 6'h00;       // ext, int, load, short, dis oc, chg oc
  wire        scl, sda_low, sda_out, sda_oe_out;
  wire        sda = ~(sda_low | sda_oe_out); // pulled up when released
  wire  [7:1] bal;
  wire  [3:0] ana;
  wire        cd, dd, lm, sl, doa, soa, coa, cdv, ddv;
  wire  [7:0] dso, cso, fso;
  integer     bad_count = 0, total_checks = 0, i;
  logic [7:0] v [3] = '{8'h90, 8'h8C, 8'h9B}; // setup values
  ////////////////////////////////////////////////////////////////////////////
  bafe_register_bank u_bafe_register_bank (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wake_pin_in(wake_pin_in),
    .ext_overtemp_in(cond[5]), .int_overtemp_in(cond[4]),
    .load_failure_in(cond[3]), .discharge_short_in(cond[2]),
    .discharge_overcurrent_in(cond[1]), .charge_overcurrent_in(cond[0]),
    .balance_switch_out(bal), .analog_select_out(ana),
    .charge_switch_drive_out(cd), .discharge_switch_drive_out(dd),
    .load_monitor_connect_out(lm), .sleep_out(sl),
    .discharge_oc_auto_on_out(doa), .short_auto_on_out(soa),
    .charge_oc_auto_on_out(coa), .charge_delay_divider_out(cdv),
    .discharge_delay_divider_out(ddv), .discharge_setup_out(dso),
    .charge_setup_out(cso), .feature_setup_out(fso));
  bafe_host_model u_bafe_host_model (
    .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));
  // 250 MHz clock
  initial forever #2 mclk_in = ~mclk_in;
  ////////////////////////////////////////////////////////////////////////////
  // checks, pin drivers, closing
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] x;
    u_bafe_host_model.rd(a, x);
    chk($sformatf("reg %h", a), x, e);
  endtask
  task setc(input logic [5:0] c);
    @(posedge mclk_in);
    #1 cond = c;
    repeat (8) @(posedge mclk_in);
  endtask
  task setw(input logic w);
    @(posedge mclk_in);
    #1 wake_pin_in = w;
    repeat (8) @(posedge mclk_in);
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // watchdog over the expected run length
  initial begin
    #200000;
    bad_count++;
    summarize;
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    repeat (4) @(posedge mclk_in);
    chk("auto", {3'h0, doa, soa, coa, cdv, ddv}, 8'h1C);
    chk("ctl", {bal, cd} | {ana, dd, lm, sl, 1'b0}, 8'h00);
    rchk(8'h00, 8'h20);
    setw(1'b0);
    rchk(8'h00, 8'h30);
    setw(1'b1);
    rchk(8'h00, 8'h20);
    $display("reset and wake status done");
    u_bafe_host_model.wr(8'h04, 8'h03);
    chk("fet", {6'h0, cd, dd}, 8'h03);
    rchk(8'h04, 8'h03);
    u_bafe_host_model.wr(8'h04, 8'h02);
    chk("fet", {6'h0, cd, dd}, 8'h02);
    for (i = 0; i < 3; i++) begin
      u_bafe_host_model.wr(8'h04, 8'h03);
      setc(6'h01 << i);
      setc(6'h00);
      chk("trip", {6'h0, cd, dd}, 8'h00);
    end
    rchk(8'h04, 8'h00);
    setc(6'h38);
    setc(6'h20);
    rchk(8'h01, 8'h3F);
    rchk(8'h01, 8'h20);
    setc(6'h00);
    rchk(8'h01, 8'h20);
    rchk(8'h01, 8'h00);
    $display("fet drive and fault flags done");
    u_bafe_host_model.wr(8'h04, 8'hC0);
    chk("sleep", {6'h0, sl, lm}, 8'h03);
    setw(1'b0);
    chk("sleep", {6'h0, sl, lm}, 8'h01);
    setw(1'b1);
    u_bafe_host_model.wr(8'h04, 8'h80);
    u_bafe_host_model.wr(8'h04, 8'h00);
    chk("sleep", {7'h0, sl}, 8'h00);
    u_bafe_host_model.wr(8'h02, 8'hFE);
    u_bafe_host_model.wr(8'h03, 8'hCF);
    rchk(8'h02, 8'hFE);
    rchk(8'h03, 8'hCF);
    chk("outs", {bal, 1'b0} ^ {ana, 4'h0}, 8'h0E);
    $display("plain registers and sleep done");
    for (i = 0; i < 3; i++) begin
      u_bafe_host_model.wr(8'h05 + i, v[i]);
      rchk(8'h05 + i, 8'h00);
      u_bafe_host_model.wr(8'h08, 8'h20 << i);
      rchk(8'h08, 8'h20 << i);
      u_bafe_host_model.wr(8'h05 + i, v[i]);
      rchk(8'h05 + i, v[i]);
      u_bafe_host_model.wr(8'h08, 8'h00);
    end
    chk("dset", dso, 8'h90);
    chk("cset", cso, 8'h8C);
    chk("fset", fso, 8'h9B);
    chk("auto", {3'h0, doa, soa, coa, cdv, ddv}, 8'h03);
    rchk(8'h00, 8'h30);
    u_bafe_host_model.wr(8'h04, 8'h83);
    setw(1'b0);
    setw(1'b1);
    setc(6'h07);
    setc(6'h00);
    chk("nowake", {5'h0, sl, cd, dd}, 8'h07);
    rchk(8'h09, 8'h00);
    $display("gated configuration done");
    summarize;
  end
endmodule
